/* File: phase_step_pkg.sv */
// constants and types shared by both ends of the phase step port
// assumes one clock (REF_CLK_IN, 40 MHz) used as the scan clock
// What this block does
// - decode 3-bit target selector on rising edge
// - direction 1 is up, 0 is down
// - 000 all outputs, 001 feedback, 010-110 outputs
// - step starts only on request high
// - controller sets direction and target first
// - controller holds request two cycles, then low
// - exactly one step per request pulse
// - controller waits for done high before next
// - request sampled on falling clock edge
// - capture and start on second rising edge
// - done drops at start, rises when finished
// - done falls on rising edge, rises internally
// - done low time fixed at four scan clock cycles
// - request pulses at least one cycle apart
// - steps repeat without limit
// - all signals synchronous to scan clock
// - controller supplies free-running scan clock; here both ends take the shared REF_CLK_IN as an input
// - each step moves tap one eighth period
// - output clocks keep running during step
package phase_step_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned HOLD_CYCLES     = 2;
    localparam int unsigned GAP_CYCLES      = 1;
    // internal settle time of a tap move, in scan clock cycles
    localparam int unsigned SETTLE_CYCLES   = 3;
    localparam int unsigned NUM_OUT_DIV     = 5;
    localparam int unsigned TAP_W           = 3;
    localparam logic [TAP_W-1:0] TAP_RESET  = 3'h0;
    localparam logic [2:0] SEL_ALL_OUT      = 3'h0;
    localparam logic [2:0] SEL_FEEDBACK     = 3'h1;
    localparam logic [2:0] SEL_OUT_BASE     = 3'h2;
    localparam logic [2:0] SEL_OUT_LAST     = 3'h6;
    localparam logic [3:0] SETTLE_W4        = 4'h3;
    localparam logic [1:0] HOLD_W2          = 2'h2;

    typedef logic [2:0] target_sel_t;
    typedef logic [TAP_W-1:0] tap_t;
    typedef enum logic [1:0] {DEV_IDLE, DEV_ARMED, DEV_SHIFT} dev_state_t;
    typedef enum logic [1:0] {CTL_IDLE, CTL_HOLD, CTL_GAP, CTL_WAIT}
        ctl_state_t;
endpackage

/* File: phase_step_if.sv */
// interface joining the controller to the phase step port
// assumes both ends run on the same scan clock
`timescale 1ns/10ps
interface phase_step_if;
    logic                      step;
    logic                      up;
    phase_step_pkg::target_sel_t target_sel;
    logic                      done;
    modport device (input step, input up, input target_sel, output done);
    modport controller (output step, output up, output target_sel,
                        input done);
endinterface

/* File: phase_step_device.sv */
// device end: step sampler, target decode and phase tap movers
// assumes scan clock REF_CLK_IN free running and one clock enable
`timescale 1ns/10ps
module phase_step_device (
    input  wire logic                         REF_CLK_IN,
    input  wire logic                         NRST_IN,
    input  wire logic                         CE_IN,
    phase_step_if.device                      link,
    output logic [phase_step_pkg::TAP_W-1:0]  FB_TAP_OUT,
    output logic [phase_step_pkg::TAP_W-1:0]  OUT_TAP_OUT [5],
    output logic                              BUSY_OUT
);
    import phase_step_pkg::*;

    logic       step_neg_r;
    logic       step_seen_r;
    logic       busy_r;
    logic       up_r;
    target_sel_t sel_r;
    logic [3:0] settle_r;
    logic       done_r;
    dev_state_t state_r;
    tap_t       fb_tap_r;
    tap_t       out_tap_r [NUM_OUT_DIV];

    // request sampled on the falling edge
    always_ff @(negedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            step_neg_r <= 1'b0;
        end else if (CE_IN) begin
            step_neg_r <= link.step;
        end
    end

    // edge detect so a long request gives only one step
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            step_seen_r <= 1'b0;
        end else if (CE_IN) begin
            step_seen_r <= step_neg_r;
        end
    end

    wire logic rise_w    = step_neg_r && !step_seen_r;
    wire logic capture_w = (state_r == DEV_ARMED);
    wire logic finish_w  = (state_r == DEV_SHIFT) && (settle_r == 4'h0);

    // armed on the first rising edge after the sample, so the next
    // rising edge is the second one and does the capture
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_r <= DEV_IDLE;
        end else if (CE_IN) begin
            unique case (state_r)
                DEV_IDLE: begin
                    if (rise_w) begin
                        state_r <= DEV_ARMED;
                    end
                end
                DEV_ARMED: begin
                    state_r <= DEV_SHIFT;
                end
                DEV_SHIFT: begin
                    if (finish_w) begin
                        state_r <= DEV_IDLE;
                    end
                end
                // unused code: fall back to idle
                default: begin
                    state_r <= DEV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            up_r  <= 1'b0;
            sel_r <= SEL_ALL_OUT;
        end else if (CE_IN && capture_w) begin
            up_r  <= link.up;
            sel_r <= link.target_sel;
        end
    end

    // stands in for analog settle; length fixed by SETTLE_W4
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            settle_r <= 4'h0;
        end else if (CE_IN) begin
            if (capture_w) begin
                settle_r <= SETTLE_W4;
            end else if (state_r == DEV_SHIFT && settle_r != 4'h0) begin
                settle_r <= settle_r - 4'h1;
            end
        end
    end

    // busy kept in its own flop so the pin needs no inverter
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            done_r <= 1'b1;
            busy_r <= 1'b0;
        end else if (CE_IN) begin
            if (capture_w) begin
                done_r <= 1'b0;
                busy_r <= 1'b1;
            end else if (finish_w) begin
                done_r <= 1'b1;
                busy_r <= 1'b0;
            end
        end
    end

    wire logic move_w = (state_r == DEV_SHIFT) && (settle_r == SETTLE_W4);

    // one eighth period per step: 3-bit tap wraps mod 8
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            fb_tap_r <= TAP_RESET;
        end else if (CE_IN && move_w && sel_r == SEL_FEEDBACK) begin
            fb_tap_r <= up_r ? fb_tap_r + 3'h1 : fb_tap_r - 3'h1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_OUT_DIV; g++) begin : g_out
            localparam target_sel_t CODE = target_sel_t'(g + 2);
            always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
                if (!NRST_IN) begin
                    out_tap_r[g] <= TAP_RESET;
                end else if (CE_IN && move_w &&
                             (sel_r == SEL_ALL_OUT || sel_r == CODE)) begin
                    out_tap_r[g] <= up_r ? out_tap_r[g] + 3'h1
                                         : out_tap_r[g] - 3'h1;
                end
            end
            assign OUT_TAP_OUT[g] = out_tap_r[g];
        end
    endgenerate

    // taps only move, clocks never gated
    assign FB_TAP_OUT = fb_tap_r;
    assign link.done  = done_r;
    assign BUSY_OUT   = busy_r;
endmodule // phase_step_device

/* File: phase_step_controller.sv */
// controller end: turns a user step request into a legal pulse
// assumes the same scan clock as the device end
`timescale 1ns/10ps
module phase_step_controller (
    input  wire logic                        REF_CLK_IN,
    input  wire logic                        NRST_IN,
    input  wire logic                        CE_IN,
    input  wire logic                        GO_IN,
    input  wire logic                        UP_IN,
    input  wire phase_step_pkg::target_sel_t TARGET_IN,
    phase_step_if.controller                 link,
    output logic                             READY_OUT
);
    import phase_step_pkg::*;

    ctl_state_t  state_r;
    logic [1:0]  cnt_r;
    logic        step_r;
    logic        up_r;
    target_sel_t sel_r;
    logic        done_s1_r;
    logic        ready_r;

    // done comes from a device flop on the same rising edge, one flop registers it
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            done_s1_r <= 1'b1;
        end else if (CE_IN) begin
            done_s1_r <= link.done;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_r <= CTL_IDLE;
            cnt_r   <= 2'h0;
            step_r  <= 1'b0;
            up_r    <= 1'b0;
            sel_r   <= SEL_ALL_OUT;
            ready_r <= 1'b1;
        end else if (CE_IN) begin
            unique case (state_r)
                CTL_IDLE: begin
                    if (GO_IN && done_s1_r) begin
                        ready_r <= 1'b0;
                        up_r    <= UP_IN;
                        sel_r   <= TARGET_IN;
                        state_r <= CTL_GAP;
                        cnt_r   <= 2'h0;
                    end
                end
                CTL_GAP: begin
                    // target settles a cycle before request
                    step_r  <= 1'b1;
                    cnt_r   <= 2'h1;
                    state_r <= CTL_HOLD;
                end
                CTL_HOLD: begin
                    // direction and target stay stable here
                    if (cnt_r == HOLD_W2) begin
                        step_r  <= 1'b0;
                        cnt_r   <= 2'h0;
                        state_r <= CTL_WAIT;
                    end else begin
                        cnt_r <= cnt_r + 2'h1;
                    end
                end
                CTL_WAIT: begin
                    // done still high until device starts; see a low first
                    if (cnt_r == 2'h0) begin
                        if (!done_s1_r) cnt_r <= 2'h1;
                    end else if (done_s1_r) begin
                        ready_r <= 1'b1;
                        state_r <= CTL_IDLE;
                    end
                end
            endcase
        end
    end

    // free-running clock is the shared REF_CLK_IN
    assign link.step       = step_r;
    assign link.up         = up_r;
    assign link.target_sel = sel_r;
    assign READY_OUT       = ready_r;
endmodule // phase_step_controller

/* File: phase_step_props.sv */
// link checker for the phase step port, both ends design code
// assumes instantiation beside the interface in the testbench
`timescale 1ns/10ps
module phase_step_props (
    input wire logic                        REF_CLK_IN,
    input wire logic                        NRST_IN,
    input wire logic                        step,
    input wire logic                        up,
    input wire phase_step_pkg::target_sel_t target_sel,
    input wire logic                        done
);
    import phase_step_pkg::*;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!NRST_IN);
    sequence s_pulse;
        step [*2] ##1 !step;
    endsequence
    sequence s_busy;
        !done ##[1:8] done;
    endsequence
    a_pulse_len: assert property ($rose(step) |-> s_pulse)
        else $error("step pulse length wrong");
    a_pulse_gap: assert property ($fell(step) |=> !step)
        else $error("step pulses too close");
    a_start_idle: assert property ($rose(step) |-> done)
        else $error("step raised while busy");
    a_done_falls: assert property ($rose(step) |-> ##2 $fell(done))
        else $error("done did not drop after step");
    a_busy_bound: assert property ($fell(done) |-> s_busy)
        else $error("done low too long");
    a_sel_hold: assert property (step |-> $stable(up) && $stable(target_sel))
        else $error("direction or target moved during step");
    a_done_cause: assert property ($fell(done) |->
        $past(step, 2) || $past(step, 3) || $past(step, 4))
        else $error("done dropped without a step");
    a_one_step: assert property ($rose(done) |-> done [*4])
        else $error("done dropped again without a new step");
endmodule // phase_step_props

/* File: pll_dynamic_phase_step_control_tb.sv */
// testbench: controller and device joined by the phase step link
// assumes the package, interface and both ends are compiled first
`timescale 1ns/10ps
module pll_dynamic_phase_step_control_tb;
    import phase_step_pkg::*;
    logic        clk = 0, nrst = 0, go = 0, up = 0, ce = 1, busy, ready;
    target_sel_t sel = '0;
    tap_t        fb, e_fb, outs [5], e_out [5];
    int          err_total = 0, n_checks = 0;
    always #12.5 clk = ~clk;
    phase_step_if link_i ();
    phase_step_controller u_phase_step_controller (.REF_CLK_IN(clk),
        .NRST_IN(nrst), .CE_IN(ce), .GO_IN(go), .UP_IN(up), .TARGET_IN(sel),
        .link(link_i), .READY_OUT(ready));
    phase_step_device u_phase_step_device (.REF_CLK_IN(clk),
        .NRST_IN(nrst), .CE_IN(ce), .link(link_i), .FB_TAP_OUT(fb),
        .OUT_TAP_OUT(outs), .BUSY_OUT(busy));
    phase_step_props u_props (.REF_CLK_IN(clk), .NRST_IN(nrst),
        .step(link_i.step), .up(link_i.up), .target_sel(link_i.target_sel),
        .done(link_i.done));
    task results;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task check_all;
        chk(fb, e_fb);
        for (int i = 0; i < 5; i++) chk(outs[i], e_out[i]);
    endtask
    task clear_model;
        e_fb = TAP_RESET;
        for (int i = 0; i < 5; i++) e_out[i] = TAP_RESET;
    endtask
    task do_step(input logic u, input target_sel_t s);
        int n;
        logic seen;
        tap_t d;
        @(negedge clk);
        up = u;
        sel = s;
        go = 1;
        @(negedge clk);
        go = 0;
        n = 0;
        seen = 0;
        // ready may still be high at first, so skip a few cycles
        while (n < 40 && !(n > 2 && ready === 1'b1)) begin
            if (busy === 1'b1) seen = 1;
            @(negedge clk);
            n++;
        end
        chk(ready, 1);
        d = u ? 3'h1 : 3'h7;
        if (s == SEL_ALL_OUT)
            for (int i = 0; i < 5; i++) e_out[i] = e_out[i] + d;
        else if (s == SEL_FEEDBACK) e_fb = e_fb + d;
        else if (s <= SEL_OUT_LAST) e_out[s - 2] = e_out[s - 2] + d;
        if (s != 3'h7) chk(seen, 1);
        check_all();
    endtask
    task t_reset;
        clear_model();
        check_all();
        chk(link_i.done, 1);
        chk(ready, 1);
    endtask
    task t_codes;
        // down first so every tap wraps below zero
        for (int s = 0; s < 8; s++) begin
            do_step(1'b0, target_sel_t'(s));
            do_step(1'b1, target_sel_t'(s));
        end
    endtask
    task t_freeze;
        // with the enable low a held request must not start a step
        @(negedge clk);
        ce = 0;
        up = 1;
        sel = SEL_FEEDBACK;
        go = 1;
        repeat (3) @(negedge clk);
        chk(ready, 1);
        chk(fb, e_fb);
        go = 0;
        ce = 1;
        repeat (3) @(negedge clk);
        check_all();
        chk(busy, 0);
    endtask
    task t_repeat;
        for (int i = 0; i < 10; i++) do_step(1'b1, SEL_OUT_LAST);
    endtask
    task t_mid_reset;
        @(negedge clk);
        nrst = 0;
        repeat (2) @(negedge clk);
        nrst = 1;
        t_reset();
        do_step(1'b1, SEL_FEEDBACK);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        results();
    end
    initial begin
        repeat (2) @(negedge clk);
        nrst = 1;
        t_reset();
        t_freeze();
        t_codes();
        t_repeat();
        t_mid_reset();
        results();
    end
endmodule // pll_dynamic_phase_step_control_tb
